// [rtl/pid_loop_pkg.sv]
package pid_loop_pkg;

   // ---------------------------------------------------------------
   // Widths and bus geometry
   // ---------------------------------------------------------------
   localparam int WORD_W = 16;
   localparam int BLOCK_WORDS = 32;
   localparam int ADDR_W = 12;
   localparam int REG_IDX_W = 6;
   localparam logic [1:0] ADDR_ALIGN = 2'h0;
   localparam logic [3:0] ADDR_HIGH_ZERO = 4'h0;

   // ---------------------------------------------------------------
   // Parameter block word indices (byte address = 4 * index)
   // ---------------------------------------------------------------
   localparam logic [4:0] W_STATUS = 5'h00;
   localparam logic [4:0] W_TARGET = 5'h01;
   localparam logic [4:0] W_MEAS = 5'h02;
   localparam logic [4:0] W_MEAS_SCALED = 5'h03;
   localparam logic [4:0] W_OUTPUT = 5'h04;
   localparam logic [4:0] W_OUTPUT_SCALED = 5'h05;
   localparam logic [4:0] W_OUT_MAX = 5'h06;
   localparam logic [4:0] W_OUT_MIN = 5'h07;
   localparam logic [4:0] W_KP = 5'h08;
   localparam logic [4:0] W_KI = 5'h09;
   localparam logic [4:0] W_KD = 5'h0A;
   localparam logic [4:0] W_FF = 5'h0B;
   localparam logic [4:0] W_DT = 5'h0C;
   localparam logic [4:0] W_DB = 5'h0D;
   localparam logic [4:0] W_MANUAL = 5'h0E;
   localparam logic [4:0] W_SCALE_MAX = 5'h11;
   localparam logic [4:0] W_SCALE_MIN = 5'h12;
   localparam logic [4:0] W_OP_COUNT = 5'h13;
   localparam logic [4:0] W_INTEG_LO = 5'h14;
   localparam logic [4:0] W_INTEG_HI = 5'h15;
   localparam logic [4:0] W_PREV_ERR = 5'h16;
   localparam logic [4:0] W_PREV_MEAS = 5'h17;

   // Registers outside the block
   localparam logic [5:0] REG_LOOP_CONTROL = 6'h20;
   localparam logic [5:0] REG_BASE_POINTER = 6'h21;

   // ---------------------------------------------------------------
   // Status word fields
   // ---------------------------------------------------------------
   localparam int ST_FORM = 0;
   localparam int ST_DIR = 2;
   localparam int ST_LIMIT = 3;
   localparam int ST_SCALE = 5;
   localparam int ST_DSRC = 6;
   localparam int ST_WINDUP_EN = 7;
   localparam int ST_DEADBAND = 8;
   localparam int ST_OVER = 9;
   localparam int ST_UNDER = 10;
   localparam int ST_PARAM = 11;
   localparam int ST_WINDUP = 12;
   localparam logic [15:0] STATUS_SW_MASK = 16'h00ED;
   localparam logic [15:0] STATUS_RESET = 16'h0000;

   // Loop control bits
   localparam int CT_RUN = 0;
   localparam int CT_PERR = 1;
   localparam int CT_MANUAL = 2;
   localparam int CT_DONE = 3;
   localparam logic [3:0] CTRL_SW_MASK = 4'h5;
   localparam logic [3:0] CTRL_RESET = 4'h0;

   // ---------------------------------------------------------------
   // Arithmetic limits
   // ---------------------------------------------------------------
   localparam logic [15:0] BASE_PTR_MAX = 16'h0700;
   localparam logic signed [31:0] OUT_FULL_MAX = 32'sh0000_7FFF;
   localparam logic signed [31:0] OUT_FULL_MIN = 32'sh0000_0000;
   localparam logic signed [31:0] WINDUP_LIMIT = 32'sh0040_0000;
   localparam int GAIN_SHIFT = 7;

   // ---------------------------------------------------------------
   // Timing
   // ---------------------------------------------------------------
   localparam int SAMPLE_UNIT_MS = 10;
   localparam int CLK_PERIOD_NS = 4;
   localparam int SAMPLE_UNIT_CYCLES =
      SAMPLE_UNIT_MS * 1000000 / CLK_PERIOD_NS;

   typedef enum logic [2:0] {
      S_IDLE = 3'h0,
      S_LOAD = 3'h1,
      S_CALC = 3'h3,
      S_STORE = 3'h2,
      S_WAIT = 3'h6
   } loop_state_t;

   function automatic logic signed [31:0] clamp32(
      input logic signed [31:0] v,
      input logic signed [31:0] lo,
      input logic signed [31:0] hi);
      if (v > hi) begin
         return hi;
      end else if (v < lo) begin
         return lo;
      end
      return v;
   endfunction

endpackage

// [rtl/pid_loop_parameter_logic.sv]
`timescale 1ns/100ps

// Summary of operation
// - Direction bit set inverts the control correction; clear keeps it.
// - Limiting bit clamps output to upper/lower limits, else 0..32767.
// - Scaling bit scales process and control values to words 17 and 18.
// - Derivative source bit selects process value rate, else error rate.
// - Windup enable bit bounds the integral accumulator.
// - Deadband flag set while process value is within deadband of target.
// - Overrange flag set when computed output exceeds upper limit.
// - Underrange flag set when computed output falls below lower limit.
// - Parameter error: base over 1792, bad scale, negative gain, etc.
// - Windup state flag set while accumulator is held at its bound.
// - Each sample: capture input, compute output, wait one interval.
// - Error magnitude within deadband leaves the output unchanged.
// - Manual control bit drives output from the manual output word.
// - Feedforward offset is added to the equation result.
// - Workspace words persist between samples; software never writes them.
// - Sample interval counts in units of 10 ms.
// - Control bits: run, parameter error, manual, calculation done.
// - Status word bit positions as defined in the package.
// - One 32-word parameter block with fixed word positions.
module pid_loop_parameter_logic #(
   parameter int TEN_MS_CYCLES = pid_loop_pkg::SAMPLE_UNIT_CYCLES
) (
   input wire logic core_clk,
   input wire logic nrst,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [pid_loop_pkg::ADDR_W-1:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   output logic [pid_loop_pkg::WORD_W-1:0] cv_out
);
   import pid_loop_pkg::*;

   logic [WORD_W-1:0] mem [BLOCK_WORDS];
   logic [WORD_W-1:0] snap [BLOCK_WORDS];
   logic [3:0] ctrl;
   logic [WORD_W-1:0] base_ptr;
   loop_state_t state;
   logic [31:0] tick_cnt;
   logic [WORD_W-1:0] unit_cnt;

   // Calculation results held between CALC and STORE
   logic [WORD_W-1:0] res_out;
   logic [WORD_W-1:0] res_out_scaled;
   logic [WORD_W-1:0] res_meas_scaled;
   logic [31:0] res_integ;
   logic [WORD_W-1:0] res_err;
   logic [4:0] res_flags;

   // ---------------------------------------------------------------
   // APB decode
   // ---------------------------------------------------------------
   logic [REG_IDX_W-1:0] idx;
   logic mapped;
   logic access;
   logic wr;
   logic user_word;

   assign idx = paddr[REG_IDX_W+1:2];
   assign mapped = (paddr[1:0] == ADDR_ALIGN) &&
                   (paddr[ADDR_W-1:8] == ADDR_HIGH_ZERO) &&
                   (idx <= REG_BASE_POINTER);
   assign access = psel && penable && pready;
   assign wr = access && pwrite && mapped;

   // Words software may store; results and workspace stay read-only
   always_comb begin
      case (idx[4:0])
         W_TARGET, W_MEAS, W_OUT_MAX, W_OUT_MIN, W_KP, W_KI, W_KD,
         W_FF, W_DT, W_DB, W_MANUAL, W_SCALE_MAX, W_SCALE_MIN: begin
            user_word = !idx[5];
         end
         default: begin
            user_word = 1'b0;
         end
      endcase
   end

   // Zero wait state: answer in the cycle after setup
   always_ff @(posedge core_clk or negedge nrst) begin
      if (!nrst) begin
         pready <= 1'b0;
         pslverr <= 1'b0;
      end else begin
         pready <= psel && !penable && !pready;
         pslverr <= psel && !penable && !pready && !mapped;
      end
   end

   // Read data is chosen in the setup cycle and held in a flop
   logic [31:0] next_rdata;

   always_comb begin
      next_rdata = 32'h0000_0000;
      if (mapped && !pwrite) begin
         if (idx == REG_LOOP_CONTROL) begin
            next_rdata = {28'h000_0000, ctrl};
         end else if (idx == REG_BASE_POINTER) begin
            next_rdata = {16'h0000, base_ptr};
         end else begin
            next_rdata = {16'h0000, mem[idx[4:0]]};
         end
      end
   end

   always_ff @(posedge core_clk or negedge nrst) begin
      if (!nrst) begin
         prdata <= 32'h0000_0000;
      end else if (psel && !penable) begin
         prdata <= next_rdata;
      end
   end

   // ---------------------------------------------------------------
   // Loop calculation
   // ---------------------------------------------------------------
   logic [15:0] st;
   logic signed [31:0] smax, smin, omax, omin, meas, tgt, err;
   logic signed [31:0] kp, ki, kd, integ, integ_next, dterm, sum, raw;
   logic signed [31:0] outv, abs_err;
   logic wind_hit, in_db, over, under, perr;
   logic base_bad;
   logic scale_bad;
   logic gain_bad;
   logic dt_bad;
   logic calc_bad;

   always_comb begin
      st = snap[W_STATUS];
      smax = 32'(signed'(snap[W_SCALE_MAX]));
      smin = 32'(signed'(snap[W_SCALE_MIN]));
      omax = 32'(signed'(snap[W_OUT_MAX]));
      omin = 32'(signed'(snap[W_OUT_MIN]));
      kp = 32'(signed'(snap[W_KP]));
      ki = 32'(signed'(snap[W_KI]));
      kd = 32'(signed'(snap[W_KD]));
      meas = 32'(signed'(snap[W_MEAS]));
      tgt = 32'(signed'(snap[W_TARGET]));
      integ = signed'({snap[W_INTEG_HI], snap[W_INTEG_LO]});
      if (st[ST_SCALE]) begin
         meas = clamp32(meas, smin, smax);
         tgt = clamp32(tgt, smin, smax);
      end
      err = tgt - meas;
      abs_err = (err < 0) ? -err : err;
      in_db = abs_err <= 32'(signed'(snap[W_DB]));
      // Bound acts before the gain shift so the flag tracks the sum
      integ_next = integ + ki * err;
      wind_hit = 1'b0;
      if (st[ST_WINDUP_EN] && (integ_next > WINDUP_LIMIT ||
          integ_next < -WINDUP_LIMIT)) begin
         integ_next = clamp32(integ_next, -WINDUP_LIMIT,
                              WINDUP_LIMIT);
         wind_hit = 1'b1;
      end
      if (st[ST_DSRC]) begin
         dterm = kd * (32'(signed'(snap[W_PREV_MEAS])) - meas);
      end else begin
         dterm = kd * (err - 32'(signed'(snap[W_PREV_ERR])));
      end
      sum = (kp * err + integ_next + dterm) >>> GAIN_SHIFT;
      if (st[ST_DIR]) begin
         sum = -sum;
      end
      raw = 32'(signed'(snap[W_FF])) + sum;
      if (in_db) begin
         raw = 32'(signed'(snap[W_OUTPUT]));
         integ_next = integ;
      end
      if (ctrl[CT_MANUAL]) begin
         raw = 32'(signed'(snap[W_MANUAL]));
      end
      over = raw > omax;
      under = raw < omin;
      base_bad = base_ptr > BASE_PTR_MAX;
      scale_bad = smin > smax;
      gain_bad = (kp < 0) || (ki < 0) || (kd < 0);
      dt_bad = snap[W_DT] == 16'h0000;
      calc_bad = raw > OUT_FULL_MAX;
      perr = base_bad || scale_bad || gain_bad || dt_bad || calc_bad;
      if (st[ST_LIMIT]) begin
         outv = clamp32(raw, omin, omax);
      end else begin
         outv = clamp32(raw, OUT_FULL_MIN, OUT_FULL_MAX);
      end
      if (perr) begin
         // Bad parameters would drive garbage; hold the last output
         outv = 32'(signed'(snap[W_OUTPUT]));
         integ_next = integ;
      end
   end

   // Results wait one cycle so the store sees settled values
   always_ff @(posedge core_clk or negedge nrst) begin
      if (!nrst) begin
         res_out <= 16'h0000;
         res_out_scaled <= 16'h0000;
         res_meas_scaled <= 16'h0000;
         res_integ <= 32'h0000_0000;
         res_err <= 16'h0000;
         res_flags <= 5'h00;
      end else if (state == S_CALC) begin
         res_out <= outv[15:0];
         res_out_scaled <= st[ST_SCALE] ?
            16'(clamp32(outv, smin, smax)) : outv[15:0];
         res_meas_scaled <= meas[15:0];
         res_integ <= integ_next;
         res_err <= err[15:0];
         res_flags <= {wind_hit, perr, under, over, in_db};
      end
   end

   // ---------------------------------------------------------------
   // Sequencer
   // ---------------------------------------------------------------
   logic unit_end;
   assign unit_end = tick_cnt == 32'(TEN_MS_CYCLES - 1);
   logic interval_done;
   // A zero interval runs as one unit rather than stalling the loop
   assign interval_done = unit_end && (unit_cnt + 16'h0001 >= snap[W_DT]);

   always_ff @(posedge core_clk or negedge nrst) begin
      if (!nrst) begin
         state <= S_IDLE;
      end else begin
         case (state)
            S_IDLE: begin
               if (ctrl[CT_RUN]) begin
                  state <= S_LOAD;
               end
            end
            S_LOAD: begin
               state <= S_CALC;
            end
            S_CALC: begin
               state <= S_STORE;
            end
            S_STORE: begin
               state <= S_WAIT;
            end
            S_WAIT: begin
               // Run cleared mid-calculation still finishes the store
               if (!ctrl[CT_RUN]) begin
                  state <= S_IDLE;
               end else if (interval_done) begin
                  state <= S_LOAD;
               end
            end
            default: begin
               state <= S_IDLE;
            end
         endcase
      end
   end

   // Interval timer in 10 ms units; a zero interval acts as one unit
   always_ff @(posedge core_clk or negedge nrst) begin
      if (!nrst) begin
         tick_cnt <= 32'h0000_0000;
         unit_cnt <= 16'h0000;
      end else if (state != S_WAIT) begin
         tick_cnt <= 32'h0000_0000;
         unit_cnt <= 16'h0000;
      end else if (unit_end) begin
         tick_cnt <= 32'h0000_0000;
         unit_cnt <= unit_cnt + 16'h0001;
      end else begin
         tick_cnt <= tick_cnt + 32'h0000_0001;
      end
   end

   // ---------------------------------------------------------------
   // Sample snapshot, one register per block word
   // ---------------------------------------------------------------
   for (genvar g = 0; g < BLOCK_WORDS; g++) begin : g_snap
      always_ff @(posedge core_clk or negedge nrst) begin
         if (!nrst) begin
            snap[g] <= 16'h0000;
         end else if (state == S_LOAD) begin
            snap[g] <= mem[g];
         end
      end
   end

   // ---------------------------------------------------------------
   // Control bits, base pointer, block storage
   // ---------------------------------------------------------------
   always_ff @(posedge core_clk or negedge nrst) begin
      if (!nrst) begin
         ctrl <= CTRL_RESET;
      end else begin
         if (wr && idx == REG_LOOP_CONTROL) begin
            ctrl[CT_RUN] <= pwdata[CT_RUN];
            ctrl[CT_MANUAL] <= pwdata[CT_MANUAL];
         end
         // Done and error bits are hardware-owned; writes skip them
         if (state == S_LOAD) begin
            ctrl[CT_DONE] <= 1'b0;
         end else if (state == S_STORE) begin
            ctrl[CT_DONE] <= 1'b1;
            ctrl[CT_PERR] <= res_flags[ST_PARAM - ST_DEADBAND];
         end
      end
   end

   always_ff @(posedge core_clk or negedge nrst) begin
      if (!nrst) begin
         base_ptr <= 16'h0000;
      end else if (wr && idx == REG_BASE_POINTER) begin
         // Range-checked only; the block always sits at word zero
         base_ptr <= pwdata[15:0];
      end
   end

   // Software owns the mode bits of the status word, hardware the flags
   logic [WORD_W-1:0] next_status;
   logic [WORD_W-1:0] sw_bits;
   logic [WORD_W-1:0] hw_bits;

   always_comb begin
      sw_bits = mem[W_STATUS] & STATUS_SW_MASK;
      hw_bits = mem[W_STATUS] & ~STATUS_SW_MASK;
      if (wr && idx == 6'(W_STATUS)) begin
         sw_bits = pwdata[WORD_W-1:0] & STATUS_SW_MASK;
      end
      if (state == S_STORE) begin
         hw_bits = 16'(res_flags) << ST_DEADBAND;
      end
      next_status = sw_bits | hw_bits;
   end

   always_ff @(posedge core_clk or negedge nrst) begin
      if (!nrst) begin
         for (int i = 0; i < BLOCK_WORDS; i++) begin
            mem[i] <= 16'h0000;
         end
      end else begin
         if (state == S_STORE) begin
            mem[W_OUTPUT] <= res_out;
            mem[W_OUTPUT_SCALED] <= res_out_scaled;
            mem[W_MEAS_SCALED] <= res_meas_scaled;
            mem[W_OP_COUNT] <= mem[W_OP_COUNT] + 16'h0001;
            mem[W_INTEG_LO] <= res_integ[15:0];
            mem[W_INTEG_HI] <= res_integ[31:16];
            mem[W_PREV_ERR] <= res_err;
            mem[W_PREV_MEAS] <= res_meas_scaled;
         end
         if (wr && user_word) begin
            mem[idx[4:0]] <= pwdata[15:0];
         end
         mem[W_STATUS] <= next_status;
      end
   end

   always_ff @(posedge core_clk or negedge nrst) begin
      if (!nrst) begin
         cv_out <= 16'h0000;
      end else if (state == S_STORE) begin
         cv_out <= res_out;
      end
   end

endmodule

// [tb/pid_loop_parameter_logic_asserts.sv]
`timescale 1ns/100ps
module pid_loop_parameter_logic_chk
   import pid_loop_pkg::*;
(
   input wire logic core_clk,
   input wire logic nrst,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [pid_loop_pkg::ADDR_W-1:0] paddr,
   input wire logic [31:0] prdata,
   input wire logic pready,
   input wire logic pslverr
);
   default clocking cb @(posedge core_clk); endclocking
   default disable iff (!nrst);
   // ---------------------------------------------
   // Bus phases
   // ---------------------------------------------
   sequence s_setup;
      psel && !penable;
   endsequence
   sequence s_access;
      psel && penable && pready;
   endsequence
   property p_answer;
      s_setup |=> s_access;
   endproperty
   property p_ready_phase;
      pready |-> psel && penable;
   endproperty
   property p_one;
      pready |=> !pready;
   endproperty
   property p_err_ready;
      pslverr |-> pready;
   endproperty
   property p_misalign;
      s_setup ##0 (paddr[1:0] != 2'h0) |=> s_access ##0 pslverr;
   endproperty
   property p_high;
      s_setup ##0 (paddr[11:8] != 4'h0) |=> s_access ##0 pslverr;
   endproperty
   property p_mapped;
      s_setup ##0 (paddr < 12'h088 && paddr[1:0] == 2'h0) |=> !pslverr;
   endproperty
   property p_err_zero;
      pslverr && !pwrite |-> prdata == 32'h0;
   endproperty
   property p_upper;
      pready && !pwrite |-> prdata[31:16] == 16'h0;
   endproperty
   a_answer: assert property (p_answer)
      else $error("no access answer after setup");
   a_ready_phase: assert property (p_ready_phase)
      else $error("ready outside access phase");
   a_one: assert property (p_one)
      else $error("ready held longer than one cycle");
   a_err_ready: assert property (p_err_ready)
      else $error("error without ready");
   a_misalign: assert property (p_misalign)
      else $error("misaligned address not refused");
   a_high: assert property (p_high)
      else $error("high address not refused");
   a_mapped: assert property (p_mapped)
      else $error("mapped address refused");
   a_err_zero: assert property (p_err_zero)
      else $error("refused read returned data");
   a_upper: assert property (p_upper)
      else $error("upper read half not zero");
endmodule
bind pid_loop_parameter_logic pid_loop_parameter_logic_chk chk_inst (
   .core_clk(core_clk), .nrst(nrst), .psel(psel), .penable(penable),
   .pwrite(pwrite), .paddr(paddr), .prdata(prdata), .pready(pready),
   .pslverr(pslverr));

// [tb/pid_loop_parameter_logic_tb.sv]
`timescale 1ns/100ps
`define CHK(g, x) begin checks_done++; if ((g) !== (x)) begin \
   err_count++; $display("[ERR] t=%0t got=%h exp=%h", $time, g, x); \
   end end
module pid_loop_parameter_logic_tb;
   import pid_loop_pkg::*;
   logic core_clk = 0;
   logic nrst = 0;
   logic psel = 0;
   logic penable = 0;
   logic pwrite = 0;
   logic [11:0] paddr = 12'h000;
   logic [31:0] pwdata = 32'h0;
   logic [31:0] prdata;
   logic pready;
   logic pslverr;
   logic [15:0] cv_out;
   int err_count = 0;
   int checks_done = 0;
   int cyc = 0;
   localparam logic [11:0] CT = 12'h080;
   always #2 core_clk = ~core_clk;
   pid_loop_parameter_logic #(.TEN_MS_CYCLES(4)) pid_loop_parameter_logic_inst (
      .core_clk(core_clk), .nrst(nrst), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
      .pready(pready), .pslverr(pslverr), .cv_out(cv_out));
   function automatic logic [11:0] ba(input logic [4:0] w);
      return {5'h00, w, 2'h0};
   endfunction
   task automatic close_out;
      if (err_count == 0 && checks_done > 0) begin
         $display("SIMULATION PASSED");
      end else begin
         $display("SIMULATION FAILED");
      end
      $finish;
   endtask
   // Hang guard: whole run needs a few hundred cycles
   always @(posedge core_clk) begin
      cyc++;
      if (cyc == 20000) begin
         err_count++;
         close_out();
      end
   end
   // ---------------------------------------------
   // Bus access
   // ---------------------------------------------
   task automatic xfer(input logic wr, input logic [11:0] a,
      input logic [31:0] d, output logic [31:0] q, output logic e);
      @(posedge core_clk);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= wr;
      paddr <= a;
      pwdata <= d;
      @(posedge core_clk);
      penable <= 1'b1;
      do begin
         @(posedge core_clk);
      end while (pready !== 1'b1);
      q = prdata;
      e = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask
   task automatic acc(input logic wr, input logic [11:0] a,
      input logic [31:0] d, input logic [31:0] x, input logic xe);
      logic [31:0] q;
      logic e;
      xfer(wr, a, d, q, e);
      `CHK(e, xe)
      if (!wr) `CHK(q, x)
   endtask
   task automatic wr(input logic [11:0] a, input logic [15:0] d);
      acc(1'b1, a, {16'h0, d}, 32'h0, 1'b0);
   endtask
   // One fresh calculation with the given settings, then readback
   task automatic step(input logic [15:0] st, ff, db, mx, mn, kp,
      input logic [3:0] c, input logic [15:0] xo, xs);
      logic [31:0] q;
      logic e;
      wr(CT, 16'h0000);
      repeat (12) @(posedge core_clk);
      wr(ba(W_STATUS), st);
      wr(ba(W_FF), ff);
      wr(ba(W_DB), db);
      wr(ba(W_OUT_MAX), mx);
      wr(ba(W_OUT_MIN), mn);
      wr(ba(W_KP), kp);
      wr(CT, {12'h000, c});
      repeat (4) @(posedge core_clk);
      for (int i = 0; i < 100; i++) begin
         xfer(1'b0, CT, 32'h0, q, e);
         if (q[CT_DONE] === 1'b1) break;
      end
      `CHK(q[CT_DONE], 1'b1)
      acc(1'b0, ba(W_OUTPUT), 0, {16'h0, xo}, 1'b0);
      `CHK(cv_out, xo)
      acc(1'b0, ba(W_STATUS), 0, {16'h0, xs}, 1'b0);
   endtask
   // ---------------------------------------------
   // Test sequence
   // ---------------------------------------------
   logic [11:0] bad [3] = '{12'h002, 12'h088, 12'h100};
   initial begin
      repeat (12) @(posedge core_clk);
      nrst <= 1'b1;
      acc(1'b0, CT, 0, 32'h0, 1'b0);
      acc(1'b0, ba(W_STATUS), 0, 32'h0, 1'b0);
      wr(ba(W_STATUS), 16'hFFFF);
      acc(1'b0, ba(W_STATUS), 0, 32'h00ED, 1'b0);
      wr(ba(W_OUTPUT), 16'h5555);
      acc(1'b0, ba(W_OUTPUT), 0, 32'h0, 1'b0);
      foreach (bad[i]) begin
         acc(1'b0, bad[i], 0, 32'h0, 1'b1);
         acc(1'b1, bad[i], 32'h1, 32'h0, 1'b1);
      end
      wr(ba(W_TARGET), 16'd100);
      wr(ba(W_MEAS), 16'd0);
      wr(ba(W_KI), 16'd0);
      wr(ba(W_KD), 16'd0);
      wr(ba(W_DT), 16'd1);
      wr(ba(W_MANUAL), 16'h1234);
      // Upper limit of zero: any positive result also raises overrange
      step(0, 200, 0, 0, 0, 128, 4'h5, 16'h1234, 16'h0200);
      step(0, 200, 0, 0, 0, 128, 4'h1, 16'd300, 16'h0200);
      step(4, 200, 0, 0, 0, 128, 4'h1, 16'd100, 16'h0204);
      step(0, 200, 200, 0, 0, 128, 4'h1, 16'd100, 16'h0300);
      step(8, 200, 0, 250, 0, 128, 4'h1, 16'd250, 16'h0208);
      step(12, 200, 0, 250, 150, 128, 4'h1, 16'd150, 16'h040C);
      step(0, 200, 0, 0, 0, 16'hFF80, 4'h1, 16'd150, 16'h0A00);
      // Stop first so the done bit is not caught mid-calculation
      wr(CT, 16'h0000);
      repeat (4) @(posedge core_clk);
      acc(1'b0, CT, 0, 32'h000A, 1'b0);
      close_out();
   end
endmodule
